// ### tb/adc_flags_monitor.sv
// Checker for the converter flag block, bound onto its top module.
// Assumes single clock domain and asynchronous active-low reset.
`timescale 1ns/1ps
module adc_flags_monitor (
    // Clock, reset and inputs
    input logic       clock, resetn, clock_enable, conv_done, sleep_select,
    input logic       rd_channel_result, rd_last_result, rd_status,
    input logic [2:0] conv_channel,
    input logic [7:0] channel_enable,
    // Outputs watched
    input logic       result_ready_flag, any_overrun_flag, asleep,
    input logic [7:0] done_flags,
    input logic [9:0] last_result_reg,
    input logic [2:0] last_channel
);
    // A store is an end of conversion on an enabled channel
    wire st = clock_enable && conv_done && channel_enable[conv_channel];
    default clocking @(posedge clock); endclocking
    default disable iff (!resetn);
    a_ready_set: assert property (st |=> result_ready_flag) else $error("ready missed");
    a_ready_clr: assert property (clock_enable && rd_last_result && !st |=> !result_ready_flag)
        else $error("ready kept");
    a_ready_hold: assert property (result_ready_flag && !rd_last_result |=> result_ready_flag)
        else $error("ready lost");
    a_ovr_set: assert property (st && result_ready_flag |=> any_overrun_flag) else $error("overrun missed");
    a_ovr_clr: assert property (clock_enable && rd_status && !st |=> !any_overrun_flag)
        else $error("overrun kept");
    a_done_set: assert property (st ##1 (clock_enable && !rd_last_result && !rd_channel_result)
        |=> done_flags[$past(conv_channel, 2)]) else $error("done missed");
    a_refuse_dis: assert property (clock_enable && conv_done && !channel_enable[conv_channel]
        |=> $stable(last_result_reg) && $stable(last_channel)) else $error("disabled stored");
    a_sleep_wait: assert property ($rose(asleep) |-> $past(conv_done) || $past(conv_done, 2))
        else $error("early sleep");
    a_sleep_rise: assert property (st && sleep_select && $past(sleep_select) ##1 sleep_select |-> ##[0:1] asleep)
        else $error("no sleep");
    // Main coincidence scenarios and sleep entry
    cover property (st && rd_channel_result);
    cover property (st && rd_status);
    cover property ($rose(asleep));
endmodule // adc_flags_monitor

bind adc_result_status_flags adc_flags_monitor i_mon (.*);

// ### tb/adc_result_status_flags_bench.sv
// Bench for the converter flag block: table of stores, then coincidences.
// Assumes the core model answers lat cycles after a request.
`timescale 1ns/1ps
module adc_result_status_flags_bench;
    logic       clock = 0, resetn = 0, req = 0, sleep_select = 0, y, clock_enable = 1;
    logic       rd_channel_result = 0, rd_last_result = 0, rd_status = 0;
    logic       conv_start, conv_done, result_ready_flag, any_overrun_flag, asleep;
    logic [2:0] rd_channel_index = 0, ch = 0, conv_channel, last_channel, c;
    logic [9:0] res = 0, conv_result, last_result_reg, channel_result_reg, r, l;
    logic [7:0] channel_enable = 8'hff, done_flags, channel_overrun_flag, en;
    logic [3:0] lat = 4'h1;
    logic [31:0] rows [4];
    int         fail_count = 0, cmp_count = 0;
    conv_core_model i_core (.clock, .req, .ch, .res, .lat, .conv_start, .conv_done, .conv_channel, .conv_result);
    adc_result_status_flags i_dut (.clock, .resetn, .clock_enable, .conv_start, .conv_done,
        .conv_channel, .conv_result, .channel_enable, .sleep_select, .rd_channel_result, .rd_channel_index,
        .rd_last_result, .rd_status, .done_flags, .channel_overrun_flag, .result_ready_flag,
        .any_overrun_flag, .last_result_reg, .last_channel, .channel_result_reg, .asleep);
    initial forever #12.5 clock = ~clock;
    task ck(input logic [31:0] g, e);
        cmp_count++;
        if (g !== e) begin
            fail_count++;
            $display("[ERR] %0t got %h want %h", $time, g, e);
        end
    endtask
    // Read strobe pulse; index is left in place for later coincident reads
    task rd(input [2:0] b, input [2:0] i);
        @(posedge clock) {rd_status, rd_last_result, rd_channel_result} <= b;
        rd_channel_index <= i;
        @(posedge clock) {rd_status, rd_last_result, rd_channel_result} <= 3'h0;
        @(posedge clock) #1;
    endtask
    // Conversion whose end meets the given reads and enable mask
    task cv(input [2:0] cc, input [9:0] rr, input [2:0] b, input [7:0] e);
        @(posedge clock) req <= 1;
        ch <= cc;
        res <= rr;
        @(posedge clock) req <= 0;
        @(posedge clock) {rd_status, rd_last_result, rd_channel_result} <= b;
        channel_enable <= e;
        @(posedge clock) {rd_status, rd_last_result, rd_channel_result} <= 3'h0;
        @(posedge clock) #1;
    endtask
    task wrap_up;
        $display("comparisons %0d mismatches %0d", cmp_count, fail_count);
        if (fail_count == 0 && cmp_count > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask
    initial begin
        rows[0] = {8'hff, 3'h0, 10'h3a5, 1'h1, 10'h3a5};
        rows[1] = {8'hff, 3'h7, 10'h05a, 1'h1, 10'h05a};
        rows[2] = {8'h7f, 3'h7, 10'h111, 1'h0, 10'h05a};
        rows[3] = {8'h08, 3'h3, 10'h2c3, 1'h1, 10'h2c3};
        repeat (4) @(posedge clock);
        resetn <= 1;
        @(posedge clock) #1;
        ck({done_flags, channel_overrun_flag, result_ready_flag, any_overrun_flag, asleep}, 0);
        for (int i = 0; i < 4; i++) begin
            {en, c, r, y, l} = rows[i];
            cv(c, r, 3'h0, en);
            rd(3'h1, c);
            ck(result_ready_flag, y);
            ck(last_result_reg, l);
            ck(channel_result_reg, l);
            ck(last_channel, c);
            rd(3'h2, c);
            ck(result_ready_flag, 0);
        end
        // Read of a third channel while a done flag is already up
        cv(1, 10'h011, 3'h0, 8'hff);
        cv(2, 10'h022, 3'h0, 8'hff);
        rd(3'h4, 3);
        cv(1, 10'h033, 3'h1, 8'hff);
        ck(result_ready_flag, 1);
        ck(any_overrun_flag, 1);
        ck(done_flags, 8'h06);
        ck(channel_overrun_flag, 8'h02);
        rd(3'h2, 3);
        ck(done_flags, 8'h04);
        // Status read meeting an end of conversion
        cv(1, 10'h044, 3'h4, 8'hff);
        ck(channel_overrun_flag, 0);
        ck({done_flags, any_overrun_flag}, 9'h0c);
        cv(4, 10'h055, 3'h4, 8'hff);
        ck(any_overrun_flag, 1);
        // Disable of another channel, then of the finishing one, at the end of a conversion
        rd(3'h4, 0);
        cv(4, 10'h066, 3'h0, 8'hfd);
        ck({result_ready_flag, any_overrun_flag, last_result_reg}, {2'h3, 10'h066});
        ck(channel_overrun_flag, 8'h10);
        cv(5, 10'h077, 3'h1, 8'hdd);
        ck({done_flags[5], last_result_reg}, 10'h066);
        // Frozen clock enable: an end of conversion and a last read are both ignored
        @(posedge clock) clock_enable <= 0;
        cv(6, 10'h099, 3'h2, 8'hff);
        @(posedge clock) clock_enable <= 1;
        @(posedge clock) #1;
        ck({result_ready_flag, last_result_reg}, {1'b1, 10'h066});
        ck(done_flags[6], 0);
        // Last read meeting an end on a disabled channel clears ready
        cv(5, 10'h0aa, 3'h2, 8'hdf);
        ck({result_ready_flag, last_result_reg}, 10'h066);
        // Sleep chosen while idle, then a slow conversion
        @(posedge clock) sleep_select <= 1;
        lat <= 4'h6;
        repeat (8) @(posedge clock);
        #1 ck(asleep, 0);
        cv(2, 10'h088, 3'h0, 8'hff);
        ck(asleep, 0);
        repeat (5) @(posedge clock);
        #1 ck(asleep, 1);
        wrap_up;
    end
    // About 125 cycles are expected; this cuts a hang short
    initial begin
        repeat (3000) @(posedge clock);
        fail_count++;
        wrap_up;
    end
endmodule // adc_result_status_flags_bench

// ### tb/conv_core_model.sv
// Behavioural conversion core: ends a conversion lat cycles after a request.
// Assumes req is a one-cycle pulse from the bench.
`timescale 1ns/1ps
module conv_core_model (
    input  logic       clock, req,
    input  logic [2:0] ch,
    input  logic [9:0] res,
    input  logic [3:0] lat,
    output logic       conv_start, conv_done,
    output logic [2:0] conv_channel,
    output logic [9:0] conv_result
);
    logic [3:0] cnt = 4'h0;
    logic [9:0] hold;
    // Result is only valid with done; otherwise it toggles so no stale value passes
    always @(posedge clock) begin
        conv_start  <= req;
        conv_done   <= (cnt == 4'h1);
        conv_result <= (cnt == 4'h1) ? hold : ~conv_result;
        if (req) begin
            cnt          <= lat;
            conv_channel <= ch;
            hold         <= res;
        end else if (cnt != 4'h0)
            cnt <= cnt - 4'h1;
    end
endmodule // conv_core_model

// ### verilog/adc_flags_defines.vh
// Constants for the converter result and status flag logic.
// Assumes inclusion by bare name from the design files of this block.
`ifndef ADC_FLAGS_DEFINES_VH
`define ADC_FLAGS_DEFINES_VH

`define NUM_CHANNELS   8
`define CHAN_IDX_W     3
`define RESULT_W       10
`define CHAN_MASK_W    8
`define RESULT_RESET   10'h000
`define FLAGS_RESET    8'h00
`define FLAG_RESET     1'b0
`define LAST_CH_RESET  3'h0

// Sleep tracking states
`define SLP_IDLE       2'h0
`define SLP_ARMED      2'h1
`define SLP_ASLEEP     2'h2

`endif

// ### verilog/adc_result_status_flags.v
// Result registers and status flags of a multi-channel converter controller.
// Assumes converter events and software read strobes are on the clock domain.
//
// Notes on behaviour
// - Only last-result read clears ready flag
// - Last read plus end: set only if stored
// - Other channel read never blocks ready set
// - Disable elsewhere still stores and sets ready
// - Status read still updates global overrun
// - Channel read with pending ready sets overrun
// - Disable elsewhere sets global and channel overrun
// - Status read clears channel overrun despite end
// - Done clears on own or last read
// - Disabled channel's done never rises
// - Channel read clears only that done
// - Idle sleep request waits for next conversion
`timescale 1ns/1ps
`include "adc_flags_defines.vh"

module adc_result_status_flags (
    // Clock, reset, enable
    input  wire                         clock,
    input  wire                         resetn,
    input  wire                         clock_enable,
    // Conversion core
    input  wire                         conv_start,
    input  wire                         conv_done,
    input  wire [`CHAN_IDX_W-1:0]       conv_channel,
    input  wire [`RESULT_W-1:0]         conv_result,
    // Software control
    input  wire [`CHAN_MASK_W-1:0]      channel_enable,
    input  wire                         sleep_select,
    // Software read strobes
    input  wire                         rd_channel_result,
    input  wire [`CHAN_IDX_W-1:0]       rd_channel_index,
    input  wire                         rd_last_result,
    input  wire                         rd_status,
    // Status and data
    output reg  [`CHAN_MASK_W-1:0]      done_flags,
    output reg  [`CHAN_MASK_W-1:0]      channel_overrun_flag,
    output reg                          result_ready_flag,
    output reg                          any_overrun_flag,
    output reg  [`RESULT_W-1:0]         last_result_reg,
    output reg  [`CHAN_IDX_W-1:0]       last_channel,
    output reg  [`RESULT_W-1:0]         channel_result_reg,
    output reg                          asleep
);

    // Every event arrives as a one-cycle strobe on this clock. All coincidences
    // between a conversion end, a channel read, a last-result read, a status
    // read and a change of the enable mask are resolved in the same edge, so
    // no ordering between them depends on which signal settles first.
    // The per-channel flags live in one small module per channel; the global
    // flags and the last-result copy live here because they look across all
    // channels at once.
    // Outputs are registered copies, so per-channel flags show one edge after
    // the internal flag, and so one edge behind the global flags and the last result.

    // One-hot decode used for the finishing, the read and the last-result channel
    function [`CHAN_MASK_W-1:0] onehot;
        input [`CHAN_IDX_W-1:0] idx;
        begin
            onehot = {{(`CHAN_MASK_W-1){1'b0}}, 1'b1} << idx;
        end
    endfunction

    // Internal per-channel state, one bit or word per channel.
    // done_vec and ovr_vec are the live flags; the outputs lag them by one
    // edge. The result words are kept per channel so a later channel read
    // returns that channel's own data even after other channels finish.
    // The running tracker only feeds the sleep decision; it does not gate
    // any flag, so a lost start strobe cannot block a result.
    wire [`CHAN_MASK_W-1:0] done_vec;
    wire [`CHAN_MASK_W-1:0] ovr_vec;
    wire [`RESULT_W-1:0]    res_vec [0:`NUM_CHANNELS-1];
    reg                     running_reg;
    reg  [`CHAN_IDX_W-1:0]  running_ch_reg;
    reg  [1:0]              sleep_state_reg;
    reg  [1:0]              sleep_state_next;

    // Store only when the finishing channel is still enabled; a channel disabled
    // mid-conversion is dropped, whatever reads happen alongside.
    wire [`CHAN_MASK_W-1:0] end_hot   = conv_done ? onehot(conv_channel) : `FLAGS_RESET;
    wire [`CHAN_MASK_W-1:0] store_hot = end_hot & channel_enable;
    wire                    stored    = |store_hot;
    wire [`CHAN_MASK_W-1:0] rd_hot    = rd_channel_result ? onehot(rd_channel_index) : `FLAGS_RESET;
    // Last-result read clears the done flag of the channel it returns
    wire [`CHAN_MASK_W-1:0] last_hot  = rd_last_result ? onehot(last_channel) : `FLAGS_RESET;
    wire                    prev_done = |(done_vec & store_hot);

    // One flag cell per channel. The done clear merges a read of that
    // channel with a last-result read that returns it; reads of other
    // channels never reach this cell, so an unrelated read cannot wipe a
    // flag that software has not seen yet. The status read clears every
    // channel overrun at once, but a fresh overrun in the same cycle wins.
    genvar g;
    generate
        for (g = 0; g < `NUM_CHANNELS; g = g + 1) begin : chan
            channel_flag u_flag (
                .clock       (clock),
                .resetn      (resetn),
                .enable      (clock_enable),
                .store       (store_hot[g]),
                .result_in   (conv_result),
                .done_clear  (rd_hot[g] | last_hot[g]),
                .ovr_clear   (rd_status),
                .done_reg    (done_vec[g]),
                .overrun_reg (ovr_vec[g]),
                .result_reg  (res_vec[g])
            );
        end
    endgenerate

    // Global flags; a store always wins over any read-triggered clear
    always @(posedge clock or negedge resetn) begin
        if (!resetn) begin
            result_ready_flag    <= `FLAG_RESET;
            any_overrun_flag     <= `FLAG_RESET;
            last_result_reg      <= `RESULT_RESET;
            last_channel         <= `LAST_CH_RESET;
            done_flags           <= `FLAGS_RESET;
            channel_overrun_flag <= `FLAGS_RESET;
            channel_result_reg   <= `RESULT_RESET;
        end else if (clock_enable) begin
            done_flags           <= done_vec;
            channel_overrun_flag <= ovr_vec;
            channel_result_reg   <= res_vec[rd_index_hold(rd_channel_index)];
            if (stored) begin
                last_result_reg   <= conv_result;
                last_channel      <= conv_channel;
                result_ready_flag <= 1'b1;
            end else if (rd_last_result) begin
                result_ready_flag <= 1'b0;
            end
            // Overrun when a new result lands on unread data.
            // Both the global ready flag and the finishing channel's own
            // done flag count as unread data: either one means software has
            // not yet collected the previous result. Testing them from the
            // registered state, not from this cycle's reads, keeps a read
            // that coincides with the end from hiding the overrun.
            // A status read clears the flag only in a cycle without a new
            // overrun, so the event is never lost behind the read.
            if (stored && (result_ready_flag || prev_done)) begin
                any_overrun_flag <= 1'b1;
            end else if (rd_status) begin
                any_overrun_flag <= 1'b0;
            end
        end
    end

    // Identity index helper keeps the read mux readable
    function [`CHAN_IDX_W-1:0] rd_index_hold;
        input [`CHAN_IDX_W-1:0] idx;
        begin
            rd_index_hold = idx;
        end
    endfunction

    // Conversion-in-progress tracker feeding the sleep logic.
    // A start and an end in one cycle count as a new conversion starting,
    // so the converter is not put to sleep under a running conversion.
    // The channel of the running conversion is kept for inspection only;
    // flag handling uses the channel that comes with the end strobe.
    // Conversion-in-progress state
    always @(posedge clock or negedge resetn) begin
        if (!resetn) begin
            running_reg    <= `FLAG_RESET;
            running_ch_reg <= `LAST_CH_RESET;
        end else if (clock_enable) begin
            if (conv_start) begin
                running_reg    <= 1'b1;
                running_ch_reg <= conv_channel;
            end else if (conv_done) begin
                running_reg    <= 1'b0;
            end
        end
    end

    // Sleep handling: IDLE waits for the mode bit, ARMED waits for a
    // conversion to finish, ASLEEP holds until the mode bit drops.
    // Clearing the mode bit in any state returns to IDLE at once.
    // Limitation: software that sets the mode bit and never starts a
    // conversion keeps the converter awake; the recommended sequence is
    // to set the bit and then issue a start.
    // Sleep request is honoured only at the end of a later conversion;
    // an idle request alone never powers down, software must start one.
    always @* begin
        sleep_state_next = sleep_state_reg;
        case (sleep_state_reg)
            `SLP_IDLE: begin
                if (sleep_select)
                    sleep_state_next = `SLP_ARMED;
            end
            `SLP_ARMED: begin
                if (!sleep_select)
                    sleep_state_next = `SLP_IDLE;
                else if (conv_done)
                    sleep_state_next = `SLP_ASLEEP;
            end
            `SLP_ASLEEP: begin
                if (!sleep_select)
                    sleep_state_next = `SLP_IDLE;
            end
            default: sleep_state_next = `SLP_IDLE;
        endcase
    end

    // Sleep state register and the registered asleep output.
    // asleep is held low while a conversion is starting or still running,
    // so the analog core is never powered down mid-conversion even if the
    // state machine has already reached ASLEEP.
    // Trade-off: this costs one extra compare per cycle but keeps the
    // output free of glitches, as it comes straight from a flip-flop.
    always @(posedge clock or negedge resetn) begin
        if (!resetn) begin
            sleep_state_reg <= `SLP_IDLE;
            asleep          <= `FLAG_RESET;
        end else if (clock_enable) begin
            sleep_state_reg <= sleep_state_next;
            asleep          <= (sleep_state_next == `SLP_ASLEEP) && !(conv_start || running_reg && !conv_done);
        end
    end

endmodule // adc_result_status_flags

// ### verilog/channel_flag.v
// One channel's done and overrun flags plus its stored result.
// Assumes the parent supplies same-clock, already qualified events.
`timescale 1ns/1ps
`include "adc_flags_defines.vh"

module channel_flag (
    // Clock and reset
    input  wire                  clock,
    input  wire                  resetn,
    input  wire                  enable,
    // Events
    input  wire                  store,
    input  wire [`RESULT_W-1:0]  result_in,
    input  wire                  done_clear,
    input  wire                  ovr_clear,
    // State
    output reg                   done_reg,
    output reg                   overrun_reg,
    output reg  [`RESULT_W-1:0]  result_reg
);

    // Set beats clear on both flags so a conversion is never dropped
    always @(posedge clock or negedge resetn) begin
        if (!resetn) begin
            done_reg    <= `FLAG_RESET;
            overrun_reg <= `FLAG_RESET;
            result_reg  <= `RESULT_RESET;
        end else if (enable) begin
            if (store) begin
                result_reg <= result_in;
                done_reg   <= 1'b1;
            end else if (done_clear) begin
                done_reg   <= 1'b0;
            end
            // A status read clears overrun alongside a new done that does not itself overrun
            if (store && done_reg && !done_clear) begin
                overrun_reg <= 1'b1;
            end else if (ovr_clear) begin
                overrun_reg <= 1'b0;
            end
        end
    end

endmodule // channel_flag
